/* host_link.v */
// Device-side host link: SPI slave with sync protocol, plus UART transmitter
`timescale 1ns/1ps
`default_nettype none
`include "host_link_defines.vh"
module host_link (
    input wire mclk, // 250 MHz system clock
    input wire rst_n, // Async reset, active low
    input wire clkEn, // Freezes all state when low
    input wire spiClk, // SPI clock pin
    input wire spi_select_n, // SPI select pin, active low
    input wire spiMosi, // SPI master out pin
    output reg spiMiso, // SPI slave out data
    output reg spiMisoOe_n, // Low while driving the output line
    input wire initDone, // Core finished initialization
    input wire msgPending, // Core has a message or event for the host
    input wire [31:0] msgWord, // Next word of the pending message
    output reg msgAdvance, // Pulse: msgWord consumed
    input wire msgLast, // msgWord is the final word
    input wire cmdAnalysed, // Pulse: core finished analysing a command
    output reg rxWordValid, // Pulse: host word received
    output reg [31:0] rxWord, // Host word, normalised to little endian
    output reg [1:0] wordSize, // Detected word size 0:8 1:16 2:32
    output reg bigEndian, // Detected host byte order
    output reg hostIrq, // Host attention line, active high
    input wire uartMode, // Select UART transport
    input wire fastBaud, // Rate raised by dedicated command
    input wire uartRts, // Host RTS pin, high means stop
    input wire uartTxValid, // Byte offered for UART transmission
    input wire [7:0] uartTxByte, // Byte to transmit
    output reg uartTxReady, // Transmitter accepted the byte
    output reg uartRx // Device-to-host UART line
);
    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    wire sClk, sSel, sMosi, sRts;
    bit_sync uClk (.mclk(mclk), .rst_n(rst_n), .clkEn(clkEn),
        .asyncIn(spiClk), .syncOut(sClk));
    bit_sync uSel (.mclk(mclk), .rst_n(rst_n), .clkEn(clkEn),
        .asyncIn(~spi_select_n), .syncOut(sSel));
    bit_sync uMosi (.mclk(mclk), .rst_n(rst_n), .clkEn(clkEn),
        .asyncIn(spiMosi), .syncOut(sMosi));
    bit_sync uRts (.mclk(mclk), .rst_n(rst_n), .clkEn(clkEn),
        .asyncIn(uartRts), .syncOut(sRts));

    reg clkPrev_q;
    wire rise = sClk & ~clkPrev_q & sSel;
    wire fall = ~sClk & clkPrev_q & sSel;

    // ----------------------------------------
    // Protocol state
    // ----------------------------------------
    localparam ST_INIT = 4'b0001;
    localparam ST_IDLE = 4'b0010;
    localparam ST_WAIT = 4'b0100;
    localparam ST_SEND = 4'b1000;
    reg [3:0] state_q;
    reg [31:0] shIn_q, shOut_q;
    reg [5:0] bitCnt_q;
    reg [1:0] byteCnt_q;
    reg sending_q, sentSync_q, dummy_q, inCmd_q, detected_q;
    reg lastLoaded_q;
    // Byte-swapped view of the whole received word, for the other byte order
    wire [31:0] le32 = {shIn_q[7:0], shIn_q[15:8], shIn_q[23:16],
        shIn_q[31:24]};
    wire isRd = shIn_q == `RD_SYNC || le32 == `RD_SYNC;
    // Word as it stands once the bit on this rising edge is in
    wire [31:0] shNext = {shIn_q[30:0], sMosi};
    wire [31:0] nxtSwap = {shNext[7:0], shNext[15:8], shNext[23:16],
        shNext[31:24]};
    wire nxtWr = shNext == `WR_SYNC || nxtSwap == `WR_SYNC;
    wire nxtRd = shNext == `RD_SYNC || nxtSwap == `RD_SYNC;
    wire nxtBig = shNext == `WR_SYNC || shNext == `RD_SYNC;
    wire [31:0] nextOut = dummy_q ? `DUMMY_WORD : msgWord;

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            clkPrev_q <= 1'b0;
            state_q <= ST_INIT;
            shIn_q <= 32'h0;
            shOut_q <= 32'h0;
            bitCnt_q <= 6'h0;
            byteCnt_q <= 2'h0;
            sending_q <= 1'b0;
            sentSync_q <= 1'b0;
            dummy_q <= 1'b0;
            inCmd_q <= 1'b0;
            detected_q <= 1'b0;
            lastLoaded_q <= 1'b0;
            spiMiso <= 1'b0;
            spiMisoOe_n <= 1'b1;
            msgAdvance <= 1'b0;
            rxWordValid <= 1'b0;
            rxWord <= 32'h0;
            wordSize <= 2'h2;
            bigEndian <= 1'b0;
            hostIrq <= 1'b0;
        end else if (clkEn) begin
            clkPrev_q <= sClk;
            msgAdvance <= 1'b0;
            rxWordValid <= 1'b0;
            if (!sSel) begin
                bitCnt_q <= 6'h0;
                spiMisoOe_n <= 1'b1;
            end else if (sending_q && bitCnt_q == 6'h0) begin
                // Reselected mid-message: first bit must stand before rise
                spiMisoOe_n <= 1'b0;
            end
            if (rise) begin
                shIn_q <= {shIn_q[30:0], sMosi};
                bitCnt_q <= bitCnt_q + 6'h1;
            end
            if (fall) begin
                if (sending_q) begin
                    spiMisoOe_n <= 1'b0;
                    spiMiso <= shOut_q[31];
                    shOut_q <= {shOut_q[30:0], 1'b0};
                end else begin
                    spiMisoOe_n <= 1'b1;
                end
            end
            // Byte boundary: count bytes toward a word, detect framing
            if (rise && bitCnt_q[2:0] == 3'h7) begin
                byteCnt_q <= byteCnt_q + 2'h1;
                if (byteCnt_q == 2'h3) begin
                    if (!detected_q && (nxtWr || nxtRd)) begin
                        detected_q <= 1'b1;
                        bigEndian <= nxtBig;
                    end
                    rxWord <= (detected_q ? bigEndian : nxtBig) ? shNext :
                        nxtSwap;
                    // Size inferred from select gaps; 32 when held low
                    rxWordValid <= ~sending_q;
                    if (state_q == ST_IDLE || state_q == ST_WAIT) begin
                        if (nxtWr) begin
                            inCmd_q <= 1'b1;
                        end
                    end
                end
            end
            if (!sSel && clkPrev_q == 1'b0 && bitCnt_q != 6'h0) begin
                wordSize <= bitCnt_q == 6'd8 ? 2'h0 :
                    (bitCnt_q == 6'd16 ? 2'h1 : 2'h2);
            end
            case (state_q)
                ST_INIT: begin
                    hostIrq <= 1'b0;
                    if (initDone) begin
                        state_q <= ST_WAIT;
                    end
                end
                ST_IDLE: begin
                    // Commands and events raise attention here; a read sync while idle also does, below
                    if ((cmdAnalysed && inCmd_q) || msgPending) begin
                        hostIrq <= 1'b1;
                        inCmd_q <= 1'b0;
                        state_q <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    hostIrq <= 1'b1;
                    if (rise && bitCnt_q[4:0] == 5'h1f && (nxtRd || nxtWr)) begin
                        hostIrq <= 1'b0;
                        dummy_q <= ~msgPending;
                        sentSync_q <= 1'b0;
                        sending_q <= 1'b1;
                        shOut_q <= `DEVICE_TO_HOST_SYNC;
                        state_q <= ST_SEND;
                    end
                end
                ST_SEND: begin
                    // Word is taken on load, so the core has a whole word
                    // time to present the next one
                    if (rise && bitCnt_q[4:0] == 5'h1f) begin
                        if (!sentSync_q) begin
                            sentSync_q <= 1'b1;
                            shOut_q <= nextOut;
                            if (!dummy_q) begin
                                msgAdvance <= 1'b1;
                                lastLoaded_q <= msgLast;
                            end
                        end else if (dummy_q || lastLoaded_q) begin
                            sending_q <= 1'b0;
                            state_q <= ST_IDLE;
                        end else begin
                            shOut_q <= nextOut;
                            msgAdvance <= 1'b1;
                            lastLoaded_q <= msgLast;
                        end
                    end
                end
                default: state_q <= ST_INIT;
            endcase
            if (!msgPending && state_q == ST_IDLE && sSel && !rise) begin
                if (isRd && bitCnt_q[4:0] == 5'h0 && byteCnt_q == 2'h0) begin
                    state_q <= ST_WAIT;
                end
            end
        end
    end

    // ----------------------------------------
    // UART transmitter, 8N1 LSB first; stop bit lasts two clocks when the next byte is already waiting
    // ----------------------------------------
    reg [11:0] baudCnt_q;
    reg [3:0] uBit_q;
    reg [9:0] uSh_q;
    wire [11:0] bitCyc = fastBaud ? `BIT_CYC_FAST : `BIT_CYC_SLOW;
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            baudCnt_q <= 12'h0;
            uBit_q <= 4'h0;
            uSh_q <= 10'h3ff;
            uartRx <= 1'b1;
            uartTxReady <= 1'b0;
        end else if (clkEn) begin
            uartTxReady <= 1'b0;
            if (uBit_q == 4'h0) begin
                uartRx <= 1'b1;
                // Hold off whole frames while host asks us to stop
                if (uartMode && uartTxValid && !sRts && !uartTxReady) begin
                    uSh_q <= {1'b1, uartTxByte, 1'b0};
                    uBit_q <= `UART_BITS;
                    baudCnt_q <= 12'h0;
                    uartTxReady <= 1'b1;
                end
            end else if (baudCnt_q == 12'h0) begin
                uartRx <= uSh_q[0];
                uSh_q <= {1'b1, uSh_q[9:1]};
                uBit_q <= uBit_q - 4'h1;
                baudCnt_q <= bitCyc - 12'h1;
            end else begin
                baudCnt_q <= baudCnt_q - 12'h1;
            end
        end
    end
endmodule
`default_nettype wire

/* host_link_defines.vh */
// Constants for the host link SPI/UART transport block
`ifndef HOST_LINK_DEFINES_VH
`define HOST_LINK_DEFINES_VH

// ----------------------------------------
// Sync words (low byte first on the wire for LE hosts)
// ----------------------------------------
`define WR_SYNC 32'h1234_5678
`define RD_SYNC 32'h8765_4321
`define DEVICE_TO_HOST_SYNC 32'habcd_dcba
`define DUMMY_WORD 32'h0000_0000

// ----------------------------------------
// UART timing
// ----------------------------------------
`define CLK_HZ 250000000
`define BAUD_DEFAULT 115200
`define BAUD_FAST 3000000
`define BIT_CYC_W 12
`define BIT_CYC_SLOW 12'd2170
`define BIT_CYC_FAST 12'd83
`define UART_BITS 4'd10

`endif

/* bit_sync.v */
// Two-flop synchroniser for inputs from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module bit_sync (
    input wire mclk, // System clock
    input wire rst_n, // Async reset, active low
    input wire clkEn, // Clock enable
    input wire asyncIn, // Unsynchronised level
    output reg syncOut // Synchronised level
);
    reg meta_q;
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= 1'b0;
            syncOut <= 1'b0;
        end else if (clkEn) begin
            meta_q <= asyncIn;
            syncOut <= meta_q;
        end
    end
endmodule
`default_nettype wire

/* host_link_sva.sv */
// Concurrent checks on the host link ports
`timescale 1ns/1ps
`default_nettype none
module host_link_sva (
    input wire mclk, // System clock
    input wire rst_n, // Async reset, active low
    input wire spi_select_n, // SPI select
    input wire spiMisoOe_n, // Output enable, low drives
    input wire initDone, // Core init done
    input wire msgPending, // Core message pending
    input wire cmdAnalysed, // Command analysed pulse
    input wire rxWordValid, // Host word pulse
    input wire hostIrq, // Attention line
    input wire uartMode, // UART transport
    input wire uartRts, // Host RTS
    input wire uartTxReady, // UART accept pulse
    input wire uartRx // UART line to host
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    // ----------------------------------------
    // Attention line
    // ----------------------------------------
    a_irq_init_low: assert property (!initDone |-> !hostIrq)
        else $error("attention high before init");
    a_irq_rise: assert property ($rose(initDone) |-> ##[1:2] hostIrq)
        else $error("attention late after init");
    a_cmd_irq: assert property (cmdAnalysed |-> ##[1:3] hostIrq)
        else $error("no attention after command");
    a_irq_wake: assert property ($rose(msgPending) && uartMode && uartRts
        |-> ##[1:3] hostIrq)
        else $error("no wake while RTS raised");
    // ----------------------------------------
    // SPI and UART lines
    // ----------------------------------------
    a_oe_idle: assert property (spi_select_n [*6] |-> spiMisoOe_n)
        else $error("output driven while deselected");
    a_no_rx_idle: assert property (spi_select_n [*6] |-> !rxWordValid)
        else $error("word taken while deselected");
    a_rxv_gap: assert property (rxWordValid |=> !rxWordValid [*8])
        else $error("word pulses too close");
    a_uart_rts: assert property (uartRts [*5] |-> !uartTxReady)
        else $error("frame started while RTS raised");
    a_tx_start: assert property (uartTxReady |-> ##[0:4] !uartRx)
        else $error("no start bit after accept");
    cover property ($fell(hostIrq));
    cover property (uartTxReady);
    cover property (rxWordValid);
endmodule
bind host_link host_link_sva u_sva (.mclk(mclk), .rst_n(rst_n),
    .spi_select_n(spi_select_n), .spiMisoOe_n(spiMisoOe_n),
    .initDone(initDone), .msgPending(msgPending),
    .cmdAnalysed(cmdAnalysed), .rxWordValid(rxWordValid),
    .hostIrq(hostIrq), .uartMode(uartMode), .uartRts(uartRts),
    .uartTxReady(uartTxReady), .uartRx(uartRx));
`default_nettype wire

/* spi_host_model.sv */
// Host SPI master model for the link pins
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
    output logic spiClk, // Link clock, idles low
    output logic spi_select_n, // Select, active low
    output logic spiMosi, // Host data out
    input wire logic spiMiso, // Device data
    input wire logic spiMisoOe_n // Low while device drives
);
    logic lastBit = 1'b0;
    initial begin
        spiClk = 1'b0;
        spi_select_n = 1'b1;
        spiMosi = 1'b1;
    end
    // One word, MSB first; keep leaves select low for the message
    task automatic xfer(input logic [31:0] tx, input bit keep,
            output logic [31:0] rx);
        spi_select_n = 1'b0;
        for (int i = 31; i >= 0; i--) begin
            spiMosi = tx[i];
            #24 spiClk = 1'b1;
            rx[i] = spiMisoOe_n ? ~lastBit : spiMiso;
            lastBit = rx[i];
            #24 spiClk = 1'b0;
        end
        spiMosi = ~spiMosi;
        #24 spi_select_n = !keep;
        #48;
    endtask
    // Shared bus traffic for another slave
    task automatic idle();
        repeat (8) begin
            #24 spiClk = 1'b1;
            #24 spiClk = 1'b0;
        end
    endtask
endmodule
`default_nettype wire

/* host_link_tb_top.sv */
// Self-checking testbench for the host link block
`timescale 1ns/1ps
`default_nettype none
`include "host_link_defines.vh"
module host_link_tb_top;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic initDone = 1'b0;
    logic msgPending = 1'b0;
    logic cmdAnalysed = 1'b0;
    logic uartMode = 1'b0;
    logic fastBaud = 1'b0;
    logic uartRts = 1'b0;
    logic uartTxValid = 1'b0;
    logic [7:0] uartTxByte = 8'h00;
    logic [31:0] msg [0:2];
    logic [31:0] w;
    logic [31:0] gotWord;
    logic gotStb = 1'b0;
    int idx = 0;
    int errors = 0;
    int tests_run = 0;
    int seed = 61;
    logic [31:0] expQ [$];
    logic [7:0] uExp [$];
    wire spiClk, spi_select_n, spiMosi, spiMiso, spiMisoOe_n, msgAdvance;
    wire rxWordValid, bigEndian, hostIrq, uartTxReady, uartRx;
    wire [31:0] rxWord;
    wire [1:0] wordSize;
    wire [31:0] msgWord = msg[idx % 3];
    wire msgLast = (idx == 2);
    initial forever #2 mclk = ~mclk;
    host_link u_dut (.mclk(mclk), .rst_n(rst_n), .clkEn(1'b1),
        .spiClk(spiClk), .spi_select_n(spi_select_n), .spiMosi(spiMosi),
        .spiMiso(spiMiso), .spiMisoOe_n(spiMisoOe_n), .initDone(initDone),
        .msgPending(msgPending), .msgWord(msgWord), .msgAdvance(msgAdvance),
        .msgLast(msgLast), .cmdAnalysed(cmdAnalysed),
        .rxWordValid(rxWordValid), .rxWord(rxWord), .wordSize(wordSize),
        .bigEndian(bigEndian), .hostIrq(hostIrq), .uartMode(uartMode),
        .fastBaud(fastBaud), .uartRts(uartRts), .uartTxValid(uartTxValid),
        .uartTxByte(uartTxByte), .uartTxReady(uartTxReady), .uartRx(uartRx));
    spi_host_model u_host (.spiClk(spiClk), .spi_select_n(spi_select_n),
        .spiMosi(spiMosi), .spiMiso(spiMiso), .spiMisoOe_n(spiMisoOe_n));
    // Core side: three-word message, pending drops after the last
    always @(posedge mclk) begin
        if (msgAdvance) begin
            idx <= idx + 1;
            if (msgLast) msgPending <= 1'b0;
        end
    end
    task automatic chk32(input string n, input logic [31:0] e, g);
        tests_run++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic chk1(input string n, input logic e, g);
        chk32(n, {31'h0, e}, {31'h0, g});
    endtask
    task automatic test_done;
        if (errors == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic waitIrq(input logic v);
        for (int i = 0; i < 64 && hostIrq !== v; i++) @(posedge mclk);
    endtask
    // Read sync, hunt for the device sync word, then read n words (one dummy word when n is 0)
    task automatic hostRead(input int n, input bit keep);
        int k;
        u_host.xfer(`RD_SYNC, keep, w);
        waitIrq(1'b0);
        chk1("irqDrop", 1'b0, hostIrq);
        k = 0;
        w = 32'h0;
        while (w !== `DEVICE_TO_HOST_SYNC && k < 4) begin
            u_host.xfer(32'hffff_ffff, keep, w);
            k++;
        end
        chk32("syncWord", `DEVICE_TO_HOST_SYNC, w);
        if (n == 0) expQ.push_back(`DUMMY_WORD);
        for (int i = 0; i < n; i++) expQ.push_back(msg[i]);
        for (int i = 0; i < (n > 0 ? n : 1); i++) begin
            u_host.xfer(32'hffff_ffff, keep && i < n - 1, gotWord);
            gotStb = ~gotStb;
        end
    endtask
    always @(gotStb) chk32("spiWord", expQ.pop_front(), gotWord);
    always @(negedge uartRx) begin
        logic [7:0] b;
        if (uartMode && rst_n) begin
            repeat (41) @(posedge mclk);
            chk1("uartStart", 1'b0, uartRx);
            for (int i = 0; i < 8; i++) begin
                repeat (`BIT_CYC_FAST) @(posedge mclk);
                b[i] = uartRx;
            end
            chk32("uartByte", {24'h0, uExp.pop_front()}, {24'h0, b});
        end
    end
    initial begin
        for (int i = 0; i < 3; i++) msg[i] = $random(seed);
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (20) @(posedge mclk);
        chk1("irqInit", 1'b0, hostIrq);
        u_host.idle();
        @(posedge mclk);
        initDone <= 1'b1;
        msgPending <= 1'b1;
        waitIrq(1'b1);
        chk1("irqUp", 1'b1, hostIrq);
        hostRead(3, 1'b1);
        u_host.xfer(`WR_SYNC, 1'b0, w);
        u_host.xfer($random(seed), 1'b0, w);
        repeat (40) @(posedge mclk);
        chk1("irqData", 1'b0, hostIrq);
        u_host.xfer(`WR_SYNC, 1'b1, w);
        u_host.xfer(32'h0000_0001, 1'b0, w);
        chk32("rxWord", 32'h0000_0001, rxWord);
        chk32("wordSize", 32'h2, {30'h0, wordSize});
        chk1("bigEndian", 1'b1, bigEndian);
        @(posedge mclk);
        cmdAnalysed <= 1'b1;
        @(posedge mclk);
        cmdAnalysed <= 1'b0;
        waitIrq(1'b1);
        chk1("irqCmd", 1'b1, hostIrq);
        hostRead(0, 1'b0);
        for (int i = 0; i < 3; i++) msg[i] = $random(seed);
        @(posedge mclk);
        idx <= 0;
        msgPending <= 1'b1;
        waitIrq(1'b1);
        chk1("irqEvent", 1'b1, hostIrq);
        hostRead(3, 1'b0);
        @(posedge mclk);
        uartMode <= 1'b1;
        fastBaud <= 1'b1;
        uartRts <= 1'b1;
        repeat (4) @(posedge mclk);
        uartTxValid <= 1'b1;
        uartTxByte <= $random(seed);
        repeat (50) @(posedge mclk);
        chk1("txHeld", 1'b1, uartRx);
        idx <= 0;
        msgPending <= 1'b1;
        waitIrq(1'b1);
        chk1("irqWake", 1'b1, hostIrq);
        uExp.push_back(uartTxByte);
        uartRts <= 1'b0;
        for (int i = 0; i < 200; i++) begin
            @(posedge mclk);
            if (uartTxReady === 1'b1) break;
        end
        uartTxValid <= 1'b0;
        for (int i = 0; i < 2000 && uExp.size() > 0; i++) @(posedge mclk);
        chk32("uartLeft", 32'h0, uExp.size());
        test_done();
    end
    initial begin
        #200000;
        errors++;
        test_done();
    end
endmodule
`default_nettype wire
